// *** logic/timer_regs.svh ***
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register byte offsets on the AXI4-Lite bus
`define OFS_CONTROL 8'h00
`define OFS_MODE 8'h04
`define OFS_COUNT_LOW 8'h08
`define OFS_COUNT_HIGH 8'h0C
`define OFS_RELOAD_LOW 8'h10
`define OFS_RELOAD_HIGH 8'h14

// Control register field positions
`define CTL_OVERFLOW 7
`define CTL_EXT_TOGGLE 6
`define CTL_RECEIVE_CLK 5
`define CTL_TRANSMIT_CLK 4
`define CTL_EXT_ENABLE 3
`define CTL_RUN 2
`define CTL_TIMER_COUNTER 1
`define CTL_CAPTURE_RELOAD 0

// Mode register field positions
`define MOD_CLOCK_OUT 1
`define MOD_UPDOWN 0

// Reset values
`define RST_CONTROL 8'h00
`define RST_MODE 2'h0
`define RST_BYTE 8'h00

// Oscillator prescale ratio in timer operation
`define OSC_DIVIDE 4'hC

// Count limits
`define COUNT_TOP 16'hFFFF
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** logic/timer_pkg.sv ***
`default_nettype none

package timer_pkg;

  // Operating mode picked from the clock-select and capture/reload bits
  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_BAUD
  } timer_mode_e;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CONTROL,
    SEL_MODE,
    SEL_COUNT_LOW,
    SEL_COUNT_HIGH,
    SEL_RELOAD_LOW,
    SEL_RELOAD_HIGH
  } reg_sel_e;

endpackage

`default_nettype wire

// *** logic/tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Count source select going out, count ticks and pin edges coming back
interface tick_if;
  logic timer_counter_select;
  logic count_tick;
  logic dir_fall;
  modport gen (input timer_counter_select, output count_tick, output dir_fall);
  modport core (output timer_counter_select, input count_tick, input dir_fall);
endinterface

`default_nettype wire

// *** logic/count_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

module count_tick_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic count_input_pin,
  input wire logic direction_pin,
  tick_if.gen tb
);

  logic [3:0] prescale_r; // Oscillator divider phase
  logic count_pin_r; // Last sample of the count pin
  logic dir_pin_r; // Last sample of the direction pin
  logic tick_r;
  logic fall_r;

  // *******************************
  // Prescaler and edge detectors
  // *******************************

  wire prescale_wrap = (prescale_r == (`OSC_DIVIDE - 4'h1));
  wire count_fall = count_pin_r & ~count_input_pin;
  wire tick_nxt = tb.timer_counter_select ? count_fall : prescale_wrap;

  // Divider runs free, so a run bit set mid-period gives a short first tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_r <= 4'h0;
    end else begin
      prescale_r <= prescale_wrap ? 4'h0 : prescale_r + 4'h1;
    end
  end

  // One-cycle tick per falling pin edge or per divided period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_pin_r <= 1'b1;
      dir_pin_r <= 1'b1;
      tick_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      count_pin_r <= count_input_pin;
      dir_pin_r <= direction_pin;
      tick_r <= tick_nxt;
      fall_r <= dir_pin_r & ~direction_pin;
    end
  end

  assign tb.count_tick = tick_r;
  assign tb.dir_fall = fall_r;

endmodule

`default_nettype wire

// *** logic/updown_autoreload_timer.sv ***
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

module updown_autoreload_timer
  import timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic count_input_pin,
  input wire logic direction_pin,
  output logic timer_irq,
  output logic toggle_flag_out
);

  // *******************************
  // Helpers
  // *******************************

  // Map a byte address to a register; low two bits are ignored
  function automatic reg_sel_e decode_addr(input logic [7:0] addr);
    logic [7:0] word;
    word = {addr[7:2], 2'b00};
    unique case (word)
      `OFS_CONTROL: decode_addr = SEL_CONTROL;
      `OFS_MODE: decode_addr = SEL_MODE;
      `OFS_COUNT_LOW: decode_addr = SEL_COUNT_LOW;
      `OFS_COUNT_HIGH: decode_addr = SEL_COUNT_HIGH;
      `OFS_RELOAD_LOW: decode_addr = SEL_RELOAD_LOW;
      `OFS_RELOAD_HIGH: decode_addr = SEL_RELOAD_HIGH;
      default: decode_addr = SEL_NONE;
    endcase
  endfunction

  // *******************************
  // State
  // *******************************

  logic [7:0] control_r; // Timer control register
  logic [1:0] mode_r; // Timer mode register
  logic [7:0] count_low_byte_r; // Low count byte
  logic [7:0] count_high_byte_r; // High count byte
  logic [7:0] reload_low_byte_r; // Low reload byte
  logic [7:0] reload_high_byte_r; // High reload byte
  logic aw_held_r; // Write address taken, waiting
  logic w_held_r; // Write data taken, waiting
  logic [7:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb_r; // Only lane 0 carries register data
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic timer_irq_r;
  logic toggle_flag_r;

  tick_if tick_bus ();

  count_tick_gen tick_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_input_pin(count_input_pin),
    .direction_pin(direction_pin),
    .tb(tick_bus)
  );

  // Pin edges or divided oscillator, per the select bit
  assign tick_bus.timer_counter_select = control_r[`CTL_TIMER_COUNTER];

  // *******************************
  // Field views
  // *******************************

  wire run_control = control_r[`CTL_RUN];
  wire receive_clock_select = control_r[`CTL_RECEIVE_CLK];
  wire transmit_clock_select = control_r[`CTL_TRANSMIT_CLK];
  wire capture_reload_select = control_r[`CTL_CAPTURE_RELOAD];
  wire external_enable = control_r[`CTL_EXT_ENABLE];
  wire overflow_flag = control_r[`CTL_OVERFLOW];
  wire external_toggle_flag = control_r[`CTL_EXT_TOGGLE];
  wire updown_enable = mode_r[`MOD_UPDOWN];
  wire serial_clocking = receive_clock_select | transmit_clock_select;

  // Clock selects override capture/reload: a baud clock must always reload
  wire timer_mode_e mode_w = serial_clocking ? MODE_BAUD :
    (capture_reload_select ? MODE_CAPTURE : MODE_RELOAD);

  // *******************************
  // Counting datapath
  // *******************************

  wire [15:0] count_w = {count_high_byte_r, count_low_byte_r};
  wire [15:0] reload_w = {reload_high_byte_r, reload_low_byte_r};
  wire step_w = run_control & tick_bus.count_tick;
  wire updown_active = (mode_w == MODE_RELOAD) & updown_enable;
  // Direction pin only matters with up/down on; otherwise always up
  wire count_up = ~updown_active | direction_pin;
  wire overflow_w = step_w & count_up & (count_w == `COUNT_TOP);
  wire underflow_w = step_w & ~count_up & (count_w == reload_w);
  wire wrap_w = overflow_w | underflow_w;

  // Pin falls only act as capture/reload triggers outside up/down
  wire ext_event_w = external_enable & tick_bus.dir_fall & ~updown_active;
  wire capture_w = ext_event_w & (mode_w == MODE_CAPTURE);
  wire ext_reload_w = ext_event_w & (mode_w == MODE_RELOAD);

  // Low byte carries into the high byte through the 16-bit step
  wire [15:0] count_inc = count_w + `COUNT_ONE;
  wire [15:0] count_dec = count_w - `COUNT_ONE;
  wire [15:0] overflow_load = (mode_w == MODE_CAPTURE) ? `COUNT_ZERO : reload_w;
  wire [15:0] count_hw =
    underflow_w ? `COUNT_TOP :
    overflow_w ? overflow_load :
    ext_reload_w ? reload_w :
    step_w ? (count_up ? count_inc : count_dec) :
    count_w;

  // Flag left alone while the timer clocks the serial port
  wire flag_set = wrap_w & ~serial_clocking;
  wire toggle_now = wrap_w & updown_active;

  // *******************************
  // Write decode
  // *******************************

  wire wr_go = aw_held_r & w_held_r & ~bvalid_r;
  wire reg_sel_e wr_sel = decode_addr(awaddr_r);
  wire wr_en = wr_go & wstrb_r;
  wire wr_control = wr_en & (wr_sel == SEL_CONTROL);
  wire wr_mode = wr_en & (wr_sel == SEL_MODE);
  wire wr_count_low = wr_en & (wr_sel == SEL_COUNT_LOW);
  wire wr_count_high = wr_en & (wr_sel == SEL_COUNT_HIGH);
  wire wr_reload_low = wr_en & (wr_sel == SEL_RELOAD_LOW);
  wire wr_reload_high = wr_en & (wr_sel == SEL_RELOAD_HIGH);

  // Control next value: software write, then hardware events on top
  wire [7:0] control_base = wr_control ? wdata_r : control_r;
  // Toggle follows the live bit; a set event wins over a software clear
  wire toggle_hw = toggle_now ? ~external_toggle_flag : control_base[`CTL_EXT_TOGGLE];
  wire toggle_nxt = toggle_hw | ext_event_w;
  wire overflow_nxt = control_base[`CTL_OVERFLOW] | flag_set;
  wire [7:0] control_nxt = {overflow_nxt, toggle_nxt, control_base[5:0]};

  // A bus write to a count byte wins over counting in that cycle
  wire [7:0] count_low_nxt = wr_count_low ? wdata_r : count_hw[7:0];
  wire [7:0] count_high_nxt = wr_count_high ? wdata_r : count_hw[15:8];
  wire [7:0] reload_low_nxt =
    capture_w ? count_w[7:0] : (wr_reload_low ? wdata_r : reload_low_byte_r);
  wire [7:0] reload_high_nxt =
    capture_w ? count_w[15:8] : (wr_reload_high ? wdata_r : reload_high_byte_r);

  // Toggle flag only interrupts with the up/down bit clear; in up/down it is a 17th bit
  wire irq_nxt = overflow_nxt | (toggle_nxt & ~mode_r[`MOD_UPDOWN]);

  // *******************************
  // Read decode
  // *******************************

  wire reg_sel_e rd_sel = decode_addr(araddr);
  wire [7:0] rd_byte =
    (rd_sel == SEL_CONTROL) ? control_r :
    (rd_sel == SEL_MODE) ? {6'h00, mode_r} :
    (rd_sel == SEL_COUNT_LOW) ? count_low_byte_r :
    (rd_sel == SEL_COUNT_HIGH) ? count_high_byte_r :
    (rd_sel == SEL_RELOAD_LOW) ? reload_low_byte_r :
    reload_high_byte_r;
  wire [1:0] rd_resp = (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
  wire [1:0] wr_resp = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;

  // *******************************
  // Timer registers
  // *******************************

  // Control and mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_r <= `RST_CONTROL;
      mode_r <= `RST_MODE;
    end else begin
      control_r <= control_nxt;
      mode_r <= wr_mode ? wdata_r[1:0] : mode_r;
    end
  end

  // Count bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_low_byte_r <= `RST_BYTE;
      count_high_byte_r <= `RST_BYTE;
    end else begin
      count_low_byte_r <= count_low_nxt;
      count_high_byte_r <= count_high_nxt;
    end
  end

  // Reload bytes, also the capture target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_low_byte_r <= `RST_BYTE;
      reload_high_byte_r <= `RST_BYTE;
    end else begin
      reload_low_byte_r <= reload_low_nxt;
      reload_high_byte_r <= reload_high_nxt;
    end
  end

  // Registered outputs track the flags with their next value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq_r <= 1'b0;
      toggle_flag_r <= 1'b0;
    end else begin
      timer_irq_r <= irq_nxt;
      toggle_flag_r <= toggle_nxt;
    end
  end

  // *******************************
  // AXI4-Lite write channels
  // *******************************

  wire aw_take = awvalid & awready_r;
  wire w_take = wvalid & wready_r;
  wire b_done = bvalid_r & bready;

  // Address and data taken in either order; each ready drops once held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r <= 8'h00;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r <= awaddr;
    end else if (b_done) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  // Write data holder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r <= wdata[7:0];
      wstrb_r <= wstrb[0];
    end else if (b_done) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_resp;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  // *******************************
  // AXI4-Lite read channels
  // *******************************

  // Data sampled at the address edge; no side effects on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end else if (arvalid & arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, (rd_sel == SEL_NONE) ? 8'h00 : rd_byte};
      rresp_r <= rd_resp;
    end else if (rvalid_r & rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign timer_irq = timer_irq_r;
  assign toggle_flag_out = toggle_flag_r;

endmodule

`default_nettype wire

// *** test/updown_autoreload_timer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****
// Bus handshake and flag checker
// ****
module timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic timer_irq
);
  // One clock domain, so one clocking and one reset for all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Address and data taken on the same edge
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // Response accepted by the master
  sequence b_done;
    bvalid && bready;
  endsequence

  a_write_answer: assert property (wr_taken |=> !bvalid ##1 bvalid)
    else $error("write response not two edges after take");
  a_ready_low: assert property (bvalid |-> !awready && !wready)
    else $error("write channel ready while response pending");
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  a_b_release: assert property (b_done |=> !bvalid && awready && wready)
    else $error("write channel not free after response");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one edge after take");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_r_release: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not free after answer");
  a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // Flags that feed irq clear only through a software write, so irq falls around a response
  a_irq_clear: assert property ($fell(timer_irq) |-> bvalid || $past(bvalid))
    else $error("interrupt request fell without a write");
endmodule

bind updown_autoreload_timer timer_checker chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .timer_irq(timer_irq)
);

`default_nettype wire

// *** test/pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****
// External count and direction pins
// ****
module pin_model (
  input wire logic aclk,
  output logic count_input_pin,
  output logic direction_pin
);
  int gap = 3; // Half period in cycles; the bench shortens it for a prompt source

  // Pins rest high, as a pulled-up port line would
  initial begin
    count_input_pin = 1'b1;
    direction_pin = 1'b1;
  end

  // One falling edge per pulse, each counted once
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      count_input_pin <= 1'b0;
      repeat (gap) @(posedge aclk);
      count_input_pin <= 1'b1;
      repeat (gap) @(posedge aclk);
    end
  endtask

  // Single level change on the count pin, so edge sense can be seen
  task automatic set_level(input logic lvl);
    @(posedge aclk);
    count_input_pin <= lvl;
  endtask

  // High level asks for up counting, low for down
  task automatic set_dir(input logic up);
    @(posedge aclk);
    direction_pin <= up;
  endtask
endmodule

`default_nettype wire

// *** test/updown_autoreload_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

module updown_autoreload_timer_tb;
  // ****
  // Signals
  // ****
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, timer_irq, toggle_flag_out;
  logic count_input_pin, direction_pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, lo;
  logic [1:0] r;
  int errors = 0;
  int checks = 0;
  // Register accesses: address, byte written, word read back, response
  typedef struct {logic [7:0] a; logic [7:0] d; logic [31:0] e; logic [1:0] r;} row_s;
  row_s rows [7] = '{'{`OFS_RELOAD_LOW, 8'hA5, 32'h000000A5, `RESP_OKAY},
    '{`OFS_RELOAD_HIGH, 8'h5A, 32'h0000005A, `RESP_OKAY},
    '{`OFS_COUNT_LOW, 8'h3C, 32'h0000003C, `RESP_OKAY},
    '{`OFS_COUNT_HIGH, 8'hC3, 32'h000000C3, `RESP_OKAY},
    '{`OFS_MODE, 8'h03, 32'h00000003, `RESP_OKAY},
    '{`OFS_CONTROL, 8'h08, 32'h00000008, `RESP_OKAY},
    '{8'h18, 8'h77, 32'h00000000, `RESP_SLVERR}};

  always #2.5 aclk = ~aclk;

  updown_autoreload_timer DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .count_input_pin(count_input_pin), .direction_pin(direction_pin),
    .timer_irq(timer_irq), .toggle_flag_out(toggle_flag_out));

  pin_model PINS (.aclk(aclk), .count_input_pin(count_input_pin),
    .direction_pin(direction_pin));

  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Both channels offered together; each released on its own take
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] rs,
      input logic [3:0] be = 4'hF);
    bit aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= be;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Loads mode, control and count, sends pulses, then compares the outcome
  task automatic run_case(input logic [7:0] md, input logic [7:0] ctl, input logic [15:0] cnt,
      input logic up, input int n, input logic [15:0] ecnt, input logic [7:0] ectl,
      input logic eirq, input logic etog);
    logic [31:0] l, h;
    logic [1:0] s;
    PINS.set_dir(up);
    wr(`OFS_MODE, md, s);
    wr(`OFS_CONTROL, ctl, s);
    wr(`OFS_COUNT_LOW, cnt[7:0], s);
    wr(`OFS_COUNT_HIGH, cnt[15:8], s);
    @(posedge aclk);
    chk("irq after write", {31'h0, ctl[7] | (ctl[6] & ~md[0])}, {31'h0, timer_irq});
    PINS.pulses(n);
    repeat (4) @(posedge aclk);
    rd(`OFS_CONTROL, l, s);
    chk("control", {24'h0, ectl}, l);
    rd(`OFS_COUNT_LOW, l, s);
    rd(`OFS_COUNT_HIGH, h, s);
    chk("count", {16'h0, ecnt}, {16'h0, h[7:0], l[7:0]});
    chk("irq", {31'h0, eirq}, {31'h0, timer_irq});
    chk("toggle", {31'h0, etog}, {31'h0, toggle_flag_out});
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Every register starts cleared
    for (int i = 0; i < 6; i++) begin
      rd(rows[i].a, lo, r);
      chk("reset value", 32'h0, lo);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      chk("write resp", {30'h0, rows[i].r}, {30'h0, r});
      rd(rows[i].a, lo, r);
      chk("read data", rows[i].e, lo);
      chk("read resp", {30'h0, rows[i].r}, {30'h0, r});
    end
    // Reload value is now 5AA5; a fast pin source first
    PINS.gap = 1;
    run_case(8'h00, 8'h06, 16'hFFFE, 1'b1, 2, 16'h5AA5, 8'h86, 1'b1, 1'b0);
    PINS.gap = 3;
    run_case(8'h00, 8'h06, 16'h00FF, 1'b1, 1, 16'h0100, 8'h06, 1'b0, 1'b0);
    run_case(8'h00, 8'h02, 16'h0005, 1'b1, 3, 16'h0005, 8'h02, 1'b0, 1'b0);
    run_case(8'h01, 8'h06, 16'hFFFF, 1'b1, 1, 16'h5AA5, 8'hC6, 1'b1, 1'b1);
    run_case(8'h01, 8'h46, 16'h5AA6, 1'b0, 2, 16'hFFFF, 8'h86, 1'b1, 1'b0);
    run_case(8'h00, 8'h16, 16'hFFFF, 1'b1, 1, 16'h5AA5, 8'h16, 1'b0, 1'b0);
    run_case(8'h00, 8'h26, 16'hFFFF, 1'b1, 1, 16'h5AA5, 8'h26, 1'b0, 1'b0);
    run_case(8'h00, 8'h07, 16'hFFFF, 1'b1, 1, 16'h0000, 8'h87, 1'b1, 1'b0);
    // Timer operation: 240 cycles of run should give twenty or so ticks
    wr(`OFS_COUNT_LOW, 8'h00, r);
    wr(`OFS_COUNT_HIGH, 8'h00, r);
    wr(`OFS_CONTROL, 8'h04, r);
    repeat (240) @(posedge aclk);
    wr(`OFS_CONTROL, 8'h00, r);
    rd(`OFS_COUNT_LOW, lo, r);
    chk("prescaled ticks", 32'h1, {31'h0, lo[7:0] inside {[8'h14:8'h15]}});
    // Direction pin fall with external enable: reload first, then capture
    wr(`OFS_CONTROL, 8'h08, r);
    PINS.set_dir(1'b0);
    repeat (4) @(posedge aclk);
    rd(`OFS_COUNT_HIGH, lo, r);
    chk("pin reload", 32'h5A, lo);
    rd(`OFS_CONTROL, lo, r);
    chk("pin reload flag", 32'h48, lo);
    wr(`OFS_COUNT_LOW, 8'h11, r);
    wr(`OFS_CONTROL, 8'h09, r);
    PINS.set_dir(1'b1);
    PINS.set_dir(1'b0);
    repeat (4) @(posedge aclk);
    rd(`OFS_RELOAD_LOW, lo, r);
    chk("pin capture", 32'h11, lo);
    // Lane 0 disabled: answered OKAY, register untouched
    wr(`OFS_RELOAD_HIGH, 8'h33, r, 4'hE);
    chk("masked write resp", {30'h0, `RESP_OKAY}, {30'h0, r});
    rd(`OFS_RELOAD_HIGH, lo, r);
    chk("masked write", 32'h5A, lo);
    // Count moves on the falling pin edge and not on the rise
    wr(`OFS_COUNT_LOW, 8'h00, r);
    wr(`OFS_CONTROL, 8'h06, r);
    PINS.set_level(1'b0);
    repeat (4) @(posedge aclk);
    rd(`OFS_COUNT_LOW, lo, r);
    chk("count after fall", 32'h1, lo);
    PINS.set_level(1'b1);
    repeat (4) @(posedge aclk);
    rd(`OFS_COUNT_LOW, lo, r);
    chk("count after rise", 32'h1, lo);
    // Reset with the overflow flag set and run off clears flags and registers
    wr(`OFS_CONTROL, 8'h80, r);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("irq after reset", 32'h0, {31'h0, timer_irq});
    rd(`OFS_CONTROL, lo, r);
    chk("control after reset", 32'h0, lo);
    stop_test();
  end

  // Hang guard, well beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("MISMATCH watchdog expected finish seen hang");
    stop_test();
  end
endmodule

`default_nettype wire
